/* core/cfa_pkg.sv */
// constants, types and command codes for the card file access command block
//---------------------------------------------------------------------------
//---------------------------------------------------------------------------
package cfa_pkg;
   // instruction codes
   localparam logic [7:0] CFA_INS_STATUS = 8'hf2;
   localparam logic [7:0] CFA_INS_RD_BIN = 8'hb0;
   localparam logic [7:0] CFA_INS_WR_BIN = 8'hd6;
   localparam logic [7:0] CFA_INS_RD_REC = 8'hb2;
   // status words
   localparam logic [15:0] CFA_SW_OK = 16'h9000;
   localparam logic [15:0] CFA_SW_LEN = 16'h6700;
   localparam logic [15:0] CFA_SW_SECURITY = 16'h6982;
   localparam logic [15:0] CFA_SW_STRUCT = 16'h6981;
   localparam logic [15:0] CFA_SW_NO_REC = 16'h6a83;
   localparam logic [15:0] CFA_SW_P1P2 = 16'h6b00;
   localparam logic [15:0] CFA_SW_INS = 16'h6d00;
   // status query parameter codes
   localparam logic [7:0] CFA_P1_NONE = 8'h00;
   localparam logic [7:0] CFA_P1_INIT = 8'h01;
   localparam logic [7:0] CFA_P1_TERM = 8'h02;
   localparam logic [7:0] CFA_P2_SELECT = 8'h00;
   localparam logic [7:0] CFA_P2_DFNAME = 8'h01;
   localparam logic [7:0] CFA_P2_NODATA = 8'h0c;
   // binary and record parameter fields
   localparam logic [2:0] CFA_P1_SFI_TAG = 3'b100;
   localparam logic [4:0] CFA_SFI_RESERVED = 5'h1f;
   localparam logic [2:0] CFA_MODE_NEXT = 3'b010;
   localparam logic [2:0] CFA_MODE_PREV = 3'b011;
   localparam logic [2:0] CFA_MODE_ABS = 3'b100;
   localparam logic [7:0] CFA_REC_CURRENT = 8'h00;
   localparam logic [8:0] CFA_LE_ZERO_CNT = 9'd256;
   // reset values
   localparam logic [7:0] CFA_PTR_RST = 8'h00;
   localparam logic [15:0] CFA_ADDR_RST = 16'h0000;

   typedef enum logic [1:0] {
      CFA_FT_TRANSPARENT, CFA_FT_LINEAR, CFA_FT_CYCLIC, CFA_FT_OTHER
   } cfa_ftype_e;
   typedef enum logic [1:0] {CFA_SRC_FILE, CFA_SRC_FCP, CFA_SRC_DFNAME} cfa_src_e;
   typedef enum logic [1:0] {CFA_IDLE, CFA_READ, CFA_WRITE} cfa_state_e;

   typedef struct packed {
      logic [7:0] cla;
      logic [7:0] ins;
      logic [7:0] p1;
      logic [7:0] p2;
      logic [7:0] lc;
      logic [7:0] le;
      logic le_present;
   } cfa_cmd_s;

   typedef struct packed {
      cfa_ftype_e ftype;
      logic [15:0] size;
      logic [7:0] rec_len;
      logic [7:0] rec_cnt;
      logic read_ok;
      logic update_ok;
      logic [7:0] fcp_len;
      logic [7:0] dfname_len;
   } cfa_finfo_s;

   typedef struct packed {
      cfa_state_e st;
      cfa_src_e src;
      logic [15:0] addr;
      logic [8:0] cnt;
      logic [7:0] ptr;
      logic ptr_set;
      logic rvalid;
      logic [7:0] rdata;
      logic rlast;
      logic done;
      logic [15:0] sw;
      logic we;
      logic [15:0] waddr;
      logic [7:0] wdata;
      logic sfi_used;
      logic [4:0] short_file_id;
      logic ind_init;
      logic ind_term;
   } cfa_state_s;
endpackage

/* core/cfa_core.sv */
// command interpreter for card file access commands
`timescale 1ns/1ps
`default_nettype none
module cfa_core (
   input wire logic clk, // 50 MHz clock
   input wire logic rstn, // synchronous reset, active low
   input wire logic cmd_valid, // command message present
   output logic cmd_ready, // command taken this cycle
   input wire cfa_pkg::cfa_cmd_s cmd, // command header fields
   input wire cfa_pkg::cfa_finfo_s finfo, // target file description
   input wire logic file_sel, // new file selected, pointer cleared unless a next/previous record read finds a record that cycle
   input wire logic [7:0] mem_rdata, // byte at mem_raddr, same cycle
   output logic [15:0] mem_raddr, // read byte address
   output cfa_pkg::cfa_src_e mem_src, // which object is read
   output logic mem_we, // write strobe
   output logic [15:0] mem_waddr, // write byte address
   output logic [7:0] mem_wdata, // write byte
   input wire logic wr_valid, // write data byte present
   input wire logic [7:0] wr_data, // write data byte
   output logic wr_ready, // write data byte taken
   output logic resp_valid, // response byte present
   output logic [7:0] resp_data, // response byte
   output logic resp_last, // final response byte
   output logic done, // command finished, sw valid
   output logic [15:0] sw, // status word
   output logic sfi_used, // short file id addressing used
   output logic [4:0] short_file_id, // short file id
   output logic app_init_ind, // application initialized pulse
   output logic app_term_ind, // application termination pulse
   output logic [7:0] rec_ptr, // record pointer
   output logic rec_ptr_set // record pointer valid
);
   import cfa_pkg::*;

   //------------------------------------------------------------------------
   // helper functions
   //------------------------------------------------------------------------
   // byte offset of a record, records numbered from one
   function automatic logic [15:0] rec_base(input logic [7:0] rec,
                                            input logic [7:0] len);
      logic [15:0] p;
      p = {8'h00, rec - 8'd1} * {8'h00, len};
      return p;
   endfunction

   // answer length: whole object unless le asks for fewer bytes
   function automatic logic [8:0] cap_len(input logic [7:0] avail,
                                          input logic [7:0] le,
                                          input logic le_present);
      if (!le_present || le == 8'h00 || le > avail) begin
         return {1'b0, avail};
      end
      return {1'b0, le};
   endfunction

   // record choice per mode: {found, record number}
   function automatic logic [8:0] rec_pick(input logic [2:0] mode,
                                           input logic [7:0] p1,
                                           input logic [7:0] ptr,
                                           input logic set,
                                           input logic [7:0] n,
                                           input logic cyc);
      logic [8:0] res;
      res = 9'h000;
      if (n != 8'h00) begin
         case (mode)
            CFA_MODE_ABS: begin
               if (p1 == CFA_REC_CURRENT) begin
                  res = {set, ptr};
               end else if (p1 <= n) begin
                  res = {1'b1, p1};
               end
            end
            CFA_MODE_NEXT: begin
               if (!set) begin
                  res = {1'b1, 8'd1};
               end else if (ptr >= n) begin
                  res = cyc ? {1'b1, 8'd1} : 9'h000;
               end else begin
                  res = {1'b1, ptr + 8'd1};
               end
            end
            CFA_MODE_PREV: begin
               if (!set) begin
                  res = {1'b1, n};
               end else if (ptr <= 8'd1) begin
                  res = cyc ? {1'b1, n} : 9'h000;
               end else begin
                  res = {1'b1, ptr - 8'd1};
               end
            end
            default: res = 9'h000;
         endcase
      end
      return res;
   endfunction

   //------------------------------------------------------------------------
   // state and decode
   //------------------------------------------------------------------------
   cfa_state_s r, n;
   logic bin_sfi;
   logic bin_bad;
   logic [15:0] bin_off;
   logic [8:0] pick;
   logic [8:0] stlen;
   logic [2:0] rmode;
   logic [4:0] rsel;

   // parameter decode: binary offset and file id shared by read and write, record pick, status length
   always_comb begin
      bin_sfi = cmd.p1[7:5] == CFA_P1_SFI_TAG;
      bin_bad = cmd.p1[7] && !bin_sfi;
      bin_off = bin_sfi ? {8'h00, cmd.p2} : {1'b0, cmd.p1[6:0], cmd.p2};
      rmode = cmd.p2[2:0];
      rsel = cmd.p2[7:3];
      pick = rec_pick(rmode, cmd.p1, r.ptr, r.ptr_set, finfo.rec_cnt,
                      finfo.ftype == CFA_FT_CYCLIC);
      stlen = cap_len((cmd.p2 == CFA_P2_DFNAME) ? finfo.dfname_len :
                      finfo.fcp_len, cmd.le, cmd.le_present);
   end

   // next state: one command at a time, no queueing
   always_comb begin
      n = r;
      n.rvalid = 1'b0;
      n.rlast = 1'b0;
      n.done = 1'b0;
      n.we = 1'b0;
      n.ind_init = 1'b0;
      n.ind_term = 1'b0;
      if (file_sel) begin
         n.ptr = CFA_PTR_RST;
         n.ptr_set = 1'b0;
      end
      case (r.st)
         CFA_IDLE: begin
            if (cmd_valid) begin
               // errors and empty answers finish at once
               n.done = 1'b1;
               n.sw = CFA_SW_OK;
               n.sfi_used = 1'b0;
               n.src = CFA_SRC_FILE;
               case (cmd.ins)
                  CFA_INS_STATUS: begin
                     if (cmd.lc != 8'h00) begin
                        n.sw = CFA_SW_LEN;
                     end else if (cmd.p1 > CFA_P1_TERM ||
                                  (cmd.p2 != CFA_P2_SELECT &&
                                   cmd.p2 != CFA_P2_DFNAME &&
                                   cmd.p2 != CFA_P2_NODATA)) begin
                        n.sw = CFA_SW_P1P2;
                     end else begin
                        n.ind_init = cmd.p1 == CFA_P1_INIT;
                        n.ind_term = cmd.p1 == CFA_P1_TERM;
                        if (cmd.p2 != CFA_P2_NODATA && stlen != 9'd0) begin
                           n.st = CFA_READ;
                           n.done = 1'b0;
                           n.cnt = stlen;
                           n.addr = CFA_ADDR_RST;
                           n.src = (cmd.p2 == CFA_P2_DFNAME) ?
                                   CFA_SRC_DFNAME : CFA_SRC_FCP;
                        end
                     end
                  end
                  CFA_INS_RD_BIN, CFA_INS_WR_BIN: begin
                     n.sfi_used = bin_sfi;
                     n.short_file_id = cmd.p1[4:0];
                     if (bin_bad || bin_off >= finfo.size) begin
                        n.sw = CFA_SW_P1P2;
                     end else if (finfo.ftype != CFA_FT_TRANSPARENT) begin
                        n.sw = CFA_SW_STRUCT;
                     end else if (cmd.ins == CFA_INS_RD_BIN) begin
                        if (!finfo.read_ok) begin
                           n.sw = CFA_SW_SECURITY;
                        end else if (!cmd.le_present) begin
                           n.sw = CFA_SW_LEN;
                        end else begin
                           n.st = CFA_READ;
                           n.done = 1'b0;
                           n.addr = bin_off;
                           n.cnt = (cmd.le == 8'h00) ? CFA_LE_ZERO_CNT :
                                   {1'b0, cmd.le};
                        end
                     end else if (!finfo.update_ok) begin
                        n.sw = CFA_SW_SECURITY;
                     end else if (cmd.lc != 8'h00) begin
                        n.st = CFA_WRITE;
                        n.done = 1'b0;
                        n.addr = bin_off;
                        n.cnt = {1'b0, cmd.lc};
                     end
                  end
                  CFA_INS_RD_REC: begin
                     n.sfi_used = rsel != 5'h00;
                     n.short_file_id = rsel;
                     if (rsel == CFA_SFI_RESERVED ||
                         (rmode != CFA_MODE_ABS && rmode != CFA_MODE_NEXT &&
                          rmode != CFA_MODE_PREV)) begin
                        n.sw = CFA_SW_P1P2;
                     end else if (finfo.ftype != CFA_FT_LINEAR &&
                                  finfo.ftype != CFA_FT_CYCLIC) begin
                        n.sw = CFA_SW_STRUCT;
                     end else if (!finfo.read_ok) begin
                        n.sw = CFA_SW_SECURITY;
                     end else if (!pick[8] || finfo.rec_len == 8'h00) begin
                        n.sw = CFA_SW_NO_REC;
                     end else begin
                        n.st = CFA_READ;
                        n.done = 1'b0;
                        n.addr = rec_base(pick[7:0], finfo.rec_len);
                        n.cnt = {1'b0, finfo.rec_len};
                        if (rmode != CFA_MODE_ABS) begin
                           n.ptr = pick[7:0];
                           n.ptr_set = 1'b1;
                        end
                     end
                  end
                  default: n.sw = CFA_SW_INS;
               endcase
            end
         end
         CFA_READ: begin
            // one byte per cycle; the receiver cannot stall
            n.rvalid = 1'b1;
            n.rdata = mem_rdata;
            n.addr = r.addr + 16'd1;
            n.cnt = r.cnt - 9'd1;
            if (r.cnt == 9'd1) begin
               n.rlast = 1'b1;
               n.done = 1'b1;
               n.sw = CFA_SW_OK;
               n.st = CFA_IDLE;
            end
         end
         CFA_WRITE: begin
            if (wr_valid) begin
               n.we = 1'b1;
               n.waddr = r.addr;
               n.wdata = wr_data;
               n.addr = r.addr + 16'd1;
               n.cnt = r.cnt - 9'd1;
               if (r.cnt == 9'd1) begin
                  n.done = 1'b1;
                  n.sw = CFA_SW_OK;
                  n.st = CFA_IDLE;
               end
            end
         end
         default: n.st = CFA_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         r <= '0;
         r.st <= CFA_IDLE;
         r.ptr <= CFA_PTR_RST;
         r.addr <= CFA_ADDR_RST;
         r.sw <= CFA_SW_OK;
      end else begin
         r <= n;
      end
   end

   //------------------------------------------------------------------------
   // outputs
   //------------------------------------------------------------------------
   // handshakes are combinational, data comes from the state register
   assign cmd_ready = r.st == CFA_IDLE;
   assign wr_ready = r.st == CFA_WRITE;
   assign mem_raddr = r.addr;
   assign mem_src = r.src;
   assign mem_we = r.we;
   assign mem_waddr = r.waddr;
   assign mem_wdata = r.wdata;
   assign resp_valid = r.rvalid;
   assign resp_data = r.rdata;
   assign resp_last = r.rlast;
   assign done = r.done;
   assign sw = r.sw;
   assign sfi_used = r.sfi_used;
   assign short_file_id = r.short_file_id;
   assign app_init_ind = r.ind_init;
   assign app_term_ind = r.ind_term;
   assign rec_ptr = r.ptr;
   assign rec_ptr_set = r.ptr_set;

   //------------------------------------------------------------------------
   // assertions
   //------------------------------------------------------------------------
   // helper: bytes sent since the read was taken
   logic [8:0] h_exp;
   logic [8:0] h_got;
   logic h_bin;
   // h_bin marks a binary read, whose length is always le (256 for le zero)
   always_ff @(posedge clk) begin
      if (!rstn) begin
         h_exp <= 9'd0;
         h_got <= 9'd0;
         h_bin <= 1'b0;
      end else if (cmd_valid && cmd_ready) begin
         h_exp <= (cmd.le == 8'h00) ? CFA_LE_ZERO_CNT : {1'b0, cmd.le};
         h_got <= 9'd0;
         h_bin <= cmd.ins == CFA_INS_RD_BIN;
      end else if (resp_valid) begin
         h_got <= h_got + 9'd1;
      end
   end

   sequence s_take(logic [7:0] ins);
      cmd_valid && cmd_ready && cmd.ins == ins && !file_sel;
   endsequence

   property p_status_no_data_in;
      @(posedge clk) disable iff (!rstn)
      s_take(CFA_INS_STATUS) ##0 cmd.lc != 8'h00
         |=> done && sw == CFA_SW_LEN && !resp_valid;
   endproperty
   a_status_no_data_in: assert property (p_status_no_data_in)
      else $error("status with input data not refused");

   property p_status_ind;
      @(posedge clk) disable iff (!rstn)
      s_take(CFA_INS_STATUS) ##0 cmd.lc == 8'h00 &&
         cmd.p1 == CFA_P1_INIT && cmd.p2 == CFA_P2_NODATA
         |=> app_init_ind && !app_term_ind && done && sw == CFA_SW_OK;
   endproperty
   a_status_ind: assert property (p_status_ind)
      else $error("application indication not reported");

   property p_status_reserved;
      @(posedge clk) disable iff (!rstn)
      s_take(CFA_INS_STATUS) ##0 cmd.lc == 8'h00 &&
         cmd.p2 == 8'h02 |=> done && sw == CFA_SW_P1P2 && !app_init_ind;
   endproperty
   a_status_reserved: assert property (p_status_reserved)
      else $error("reserved status P2 accepted");

   property p_rdbin_denied;
      @(posedge clk) disable iff (!rstn)
      s_take(CFA_INS_RD_BIN) ##0 !finfo.read_ok && !bin_bad &&
         finfo.ftype == CFA_FT_TRANSPARENT && bin_off < finfo.size
         |=> done && sw == CFA_SW_SECURITY ##1 !resp_valid;
   endproperty
   a_rdbin_denied: assert property (p_rdbin_denied)
      else $error("binary read ran without read access");

   property p_bin_offset;
      @(posedge clk) disable iff (!rstn)
      s_take(CFA_INS_RD_BIN) ##0 !cmd.p1[7] && finfo.read_ok &&
         cmd.le_present && finfo.ftype == CFA_FT_TRANSPARENT &&
         bin_off < finfo.size
         |=> mem_raddr == {1'b0, $past(cmd.p1[6:0]), $past(cmd.p2)};
   endproperty
   a_bin_offset: assert property (p_bin_offset)
      else $error("binary offset wrongly formed");

   property p_bin_sfi;
      @(posedge clk) disable iff (!rstn)
      s_take(CFA_INS_WR_BIN) ##0 cmd.p1[7:5] == CFA_P1_SFI_TAG
         |=> sfi_used && short_file_id == $past(cmd.p1[4:0]);
   endproperty
   a_bin_sfi: assert property (p_bin_sfi)
      else $error("short file id not taken from P1");

   property p_rdbin_count;
      @(posedge clk) disable iff (!rstn)
      resp_last && h_bin |-> h_got + 9'd1 == h_exp;
   endproperty
   a_rdbin_count: assert property (p_rdbin_count)
      else $error("binary read byte count differs from le");

   property p_wr_denied;
      @(posedge clk) disable iff (!rstn)
      s_take(CFA_INS_WR_BIN) ##0 !finfo.update_ok
         |=> !mem_we && !wr_ready ##1 !mem_we;
   endproperty
   a_wr_denied: assert property (p_wr_denied)
      else $error("binary write ran without update access");

   property p_rec_fail_keeps_ptr;
      @(posedge clk) disable iff (!rstn)
      s_take(CFA_INS_RD_REC) ##0 !finfo.read_ok
         |=> $stable(rec_ptr) && $stable(rec_ptr_set) && done;
   endproperty
   a_rec_fail_keeps_ptr: assert property (p_rec_fail_keeps_ptr)
      else $error("failed record read moved the pointer");

   property p_next_linear_end;
      @(posedge clk) disable iff (!rstn)
      s_take(CFA_INS_RD_REC) ##0 finfo.read_ok && rsel == 5'h00 &&
         rmode == CFA_MODE_NEXT && finfo.ftype == CFA_FT_LINEAR &&
         r.ptr_set && r.ptr == finfo.rec_cnt
         |=> $stable(rec_ptr) && sw == CFA_SW_NO_REC ##1 !resp_valid;
   endproperty
   a_next_linear_end: assert property (p_next_linear_end)
      else $error("next on last linear record not refused");

   property p_next_cyclic_wrap;
      @(posedge clk) disable iff (!rstn)
      s_take(CFA_INS_RD_REC) ##0 finfo.read_ok && rsel == 5'h00 &&
         rmode == CFA_MODE_NEXT && finfo.ftype == CFA_FT_CYCLIC &&
         r.ptr_set && r.ptr == finfo.rec_cnt && finfo.rec_len != 8'h00
         |=> rec_ptr == 8'd1 && mem_raddr == 16'h0000 ##1 resp_valid;
   endproperty
   a_next_cyclic_wrap: assert property (p_next_cyclic_wrap)
      else $error("cyclic next did not wrap to first record");
endmodule
`default_nettype wire

/* testbench/cfa_mem_model.sv */
// file store model answering the interpreter's byte reads and writes
`timescale 1ns/1ps
`default_nettype none
module cfa_mem_model (
   input wire logic clk, // bench clock
   input wire logic [15:0] raddr, // read byte address
   input wire cfa_pkg::cfa_src_e src, // object being read
   output logic [7:0] rdata, // byte read, same cycle
   input wire logic we, // write strobe
   input wire logic [15:0] waddr, // write byte address
   input wire logic [7:0] wdata // write byte
);
   import cfa_pkg::*;
   logic [7:0] mem [256];
   // high address byte folded in so offset high parts are visible
   initial begin
      for (int i = 0; i < 256; i++) mem[i] = i[7:0];
   end
   assign rdata = (src == CFA_SRC_FILE) ? mem[raddr[7:0]] ^ raddr[15:8] : 8'h5a;
   always @(posedge clk) begin
      if (we) mem[waddr[7:0]] <= wdata ^ waddr[15:8];
   end
endmodule
`default_nettype wire

/* testbench/tb.sv */
// self-checking bench for the file access command interpreter
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,a) begin \
   samples_checked++; \
   if ((a) !== (e)) begin \
      err_total++; \
      $display("mismatch %s exp %h seen %h", n, e, a); \
   end \
end
module tb;
   import cfa_pkg::*;
   logic clk = 0, rstn = 0, cmd_valid = 0, file_sel = 0, wr_valid = 1;
   logic cmd_ready, mem_we, wr_ready, resp_valid, resp_last, done;
   logic sfi_used, app_init_ind, app_term_ind, rec_ptr_set;
   cfa_cmd_s cmd = '0;
   cfa_finfo_s finfo;
   cfa_src_e mem_src;
   logic [7:0] mem_rdata, wr_data = 8'h00, resp_data, rec_ptr, mem_wdata;
   logic [15:0] mem_raddr, mem_waddr, sw;
   logic [4:0] short_file_id;
   int err_total = 0, samples_checked = 0, cnt;
   logic [7:0] b0;
   logic ind_i, ind_t;
   initial forever #10 clk = ~clk;
   cfa_core i_cfa_core (.clk, .rstn, .cmd_valid, .cmd_ready, .cmd, .finfo,
      .file_sel, .mem_rdata, .mem_raddr, .mem_src, .mem_we, .mem_waddr,
      .mem_wdata, .wr_valid, .wr_data, .wr_ready, .resp_valid, .resp_data,
      .resp_last, .done, .sw, .sfi_used, .short_file_id, .app_init_ind, .app_term_ind,
      .rec_ptr, .rec_ptr_set);
   cfa_mem_model i_cfa_mem_model (.clk, .raddr(mem_raddr), .src(mem_src),
      .rdata(mem_rdata), .we(mem_we), .waddr(mem_waddr), .wdata(mem_wdata));
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // one command; outputs sampled 1 ns after the edge so they have settled
   task automatic run(string nm, logic [7:0] ins, p1, p2, lc, le, logic lep);
      int i;
      cnt = 0;
      ind_i = 0;
      ind_t = 0;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd <= '{8'h00, ins, p1, p2, lc, le, lep};
      for (i = 0; i < 300; i++) begin
         @(posedge clk);
         #1;
         cmd_valid <= 1'b0;
         if (resp_valid === 1'b1) begin
            if (cnt == 0) b0 = resp_data;
            cnt++;
         end
         if (app_init_ind === 1'b1) ind_i = 1;
         if (app_term_ind === 1'b1) ind_t = 1;
         if (done === 1'b1) break;
      end
      if (i == 300) begin
         err_total++;
         summarize();
      end
      $display("test %s done", nm);
   endtask
   // record read with p1 left zero for next and previous
   task automatic rec(cfa_ftype_e ft, logic [7:0] p1, p2, ptr, int n);
      finfo.ftype = ft;
      run("record", CFA_INS_RD_REC, p1, p2, 8'h00, 8'h00, 1'b0);
      `CHK("rec_ptr", ptr, rec_ptr)
      `CHK("rec_bytes", n, cnt)
   endtask
   initial begin
      finfo = '{CFA_FT_TRANSPARENT, 16'h0200, 8'h02, 8'h02, 1'b1, 1'b1,
         8'h04, 8'h03};
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      run("st_init", CFA_INS_STATUS, CFA_P1_INIT, CFA_P2_NODATA, 0, 0, 0);
      `CHK("sw", CFA_SW_OK, sw)
      `CHK("init_ind", 1'b1, ind_i)
      `CHK("st_bytes", 0, cnt)
      run("st_term", CFA_INS_STATUS, CFA_P1_TERM, CFA_P2_NODATA, 0, 0, 0);
      `CHK("term_ind", 1'b1, ind_t)
      run("st_name", CFA_INS_STATUS, 0, CFA_P2_DFNAME, 0, 0, 0);
      `CHK("st_bytes", 3, cnt)
      run("st_lc", CFA_INS_STATUS, 0, CFA_P2_NODATA, 1, 0, 0);
      `CHK("sw", CFA_SW_LEN, sw)
      run("st_rfu", CFA_INS_STATUS, 0, 8'h05, 0, 0, 0);
      `CHK("sw", CFA_SW_P1P2, sw)
      run("rd_bin", CFA_INS_RD_BIN, 8'h01, 8'h02, 0, 8'h02, 1);
      `CHK("rd_bytes", 2, cnt)
      `CHK("rd_first", 8'h03, b0)
      finfo.read_ok = 0;
      run("rd_deny", CFA_INS_RD_BIN, 8'h00, 8'h04, 0, 8'h01, 1);
      `CHK("sw", CFA_SW_SECURITY, sw)
      `CHK("rd_bytes", 0, cnt)
      finfo.read_ok = 1;
      wr_data = 8'ha5;
      run("wr_bin", CFA_INS_WR_BIN, 8'h00, 8'h10, 8'h01, 0, 0);
      `CHK("sw", CFA_SW_OK, sw)
      run("rd_sfi", CFA_INS_RD_BIN, 8'h83, 8'h10, 0, 8'h01, 1);
      `CHK("rd_first", 8'ha5, b0)
      `CHK("sfi", 5'h03, short_file_id)
      `CHK("sfi_used", 1'b1, sfi_used)
      rec(CFA_FT_LINEAR, 0, 8'h02, 8'h01, 2);
      rec(CFA_FT_LINEAR, 0, 8'h02, 8'h02, 2);
      rec(CFA_FT_LINEAR, 0, 8'h02, 8'h02, 0);
      rec(CFA_FT_LINEAR, 8'h01, 8'h04, 8'h02, 2);
      rec(CFA_FT_LINEAR, 0, 8'h04, 8'h02, 2);
      `CHK("cur_first", 8'h02, b0)
      rec(CFA_FT_CYCLIC, 0, 8'h02, 8'h01, 2);
      rec(CFA_FT_CYCLIC, 0, 8'h03, 8'h02, 2);
      @(posedge clk);
      file_sel <= 1'b1;
      @(posedge clk);
      file_sel <= 1'b0;
      rec(CFA_FT_LINEAR, 0, 8'h03, 8'h02, 2);
      rec(CFA_FT_LINEAR, 0, 8'h03, 8'h01, 2);
      rec(CFA_FT_LINEAR, 0, 8'h03, 8'h01, 0);
      finfo.read_ok = 0;
      rec(CFA_FT_LINEAR, 0, 8'h02, 8'h01, 0);
      `CHK("sw", CFA_SW_SECURITY, sw)
      `CHK("ptr_set", 1'b1, rec_ptr_set)
      rec(CFA_FT_LINEAR, 8'h01, 8'hfc, 8'h01, 0);
      `CHK("sw", CFA_SW_P1P2, sw)
      `CHK("sfi_used", 1'b1, sfi_used)
      summarize();
   end
endmodule
`default_nettype wire
